/* rtl/pdcc_clock_ctrl.v */
// Dither clock control: register bank, nonvolatile shadow, gating and output divider.
`timescale 1ns/10ps
`default_nettype none
`include "pdcc_defines.vh"
module pdcc_clock_ctrl #(
  parameter [4:0]  FACTORY_BAND = 5'h12,
  parameter [23:0] NV_WRITE_CYCLES = `PDCC_NV_WRITE_MS * `PDCC_CLK_MHZ * 1000
) (
  input  wire       core_clk_i,
  input  wire       srst_i,
  input  wire       osc_clk_i,
  input  wire       dither_enable_pin_i,
  input  wire       output_enable_pin_i,
  input  wire       power_down_pin_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_oe_o,
  output reg        clk_out_o,
  output reg        osc_run_o,
  output reg  [9:0] freq_trim_o,
  output reg  [4:0] band_sel_o,
  output reg  [3:0] dither_offset_o,
  output reg        nv_busy_o
);
  // Power-down deglitch hold in core cycles: hold microseconds times clock MHz, no rounding.
  localparam [11:0] PDN_HOLD = `PDCC_PDN_HOLD_US * `PDCC_CLK_MHZ;

  reg  [7:0]  div_ctrl_q;
  reg  [7:0]  trim_hi_q;
  reg  [7:0]  trim_lo_q;
  reg  [7:0]  bus_addr_q;
  reg  [4:0]  band_q;
  reg  [7:0]  nv_div_q;
  reg  [7:0]  nv_trim_hi_q;
  reg  [7:0]  nv_trim_lo_q;
  reg  [3:0]  nv_bus_addr_q;
  reg  [4:0]  nv_band_q;
  reg         nv_valid_q = 1'b0;
  reg  [23:0] nv_cnt_q;
  reg  [7:0]  rd_data;
  reg  [2:0]  dith_sync_q;
  reg  [2:0]  oe_sync_q;
  reg  [2:0]  pdn_sync_q;
  reg  [2:0]  osc_sync_q;
  reg  [11:0] pdn_cnt_q;
  reg         pdn_low_q;
  reg  [9:0]  stab_cnt_q;
  reg         stable_q;
  reg  [8:0]  div_cnt_q;
  reg         out_gate_q;
  reg  [7:0]  tri_cnt_q;
  reg         tri_up_q;
  reg  [3:0]  exp_eff;
  wire [5:0]  reg_addr;
  wire [7:0]  wr_data;
  wire        wr_stb;
  wire        ptr_stb;

  wire osc_edge = osc_sync_q[1] & ~osc_sync_q[2];
  wire osc_fall = ~osc_sync_q[1] & osc_sync_q[2];
  wire [8:0] div_mask = (9'h001 << exp_eff) - 9'h001;
  wire div_wrap = (div_cnt_q & div_mask) == 9'h000;
  wire commit_stb = ptr_stb && (reg_addr == `PDCC_REG_COMMIT);
  wire nv_write = commit_stb || (wr_stb && (reg_addr == `PDCC_REG_BUS_ADDR || !bus_addr_q[`PDCC_WC_BIT]));

  pdcc_serial_slave u_slave (
    .core_clk_i (core_clk_i),
    .srst_i     (srst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .dev_addr_i (bus_addr_q[2:0]),
    .rd_data_i  (rd_data),
    .sda_oe_o   (sda_oe_o),
    .reg_addr_o (reg_addr),
    .wr_data_o  (wr_data),
    .ptr_stb_o  (ptr_stb),
    .wr_stb_o   (wr_stb)
  );

  always @* begin
    rd_data = 8'h00;
    if (reg_addr == `PDCC_REG_DIV) begin
      rd_data = div_ctrl_q | `PDCC_DIV_ONES;
    end else if (reg_addr == `PDCC_REG_TRIM_HI) begin
      rd_data = trim_hi_q;
    end else if (reg_addr == `PDCC_REG_TRIM_LO) begin
      rd_data = {trim_lo_q[7:6], 6'h00};
    end else if (reg_addr == `PDCC_REG_BUS_ADDR) begin
      rd_data = bus_addr_q | `PDCC_ADDR_ONES;
    end else if (reg_addr == `PDCC_REG_BAND) begin
      rd_data = {3'h7, band_q} | `PDCC_BAND_ONES;
    end else if (reg_addr == `PDCC_REG_BAND_REF) begin
      rd_data = {3'h0, FACTORY_BAND};
    end
  end

  // Working registers; power-up reloads from the nonvolatile shadow when it holds data.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      div_ctrl_q <= nv_valid_q ? nv_div_q : `PDCC_RST_DIV;
      trim_hi_q  <= nv_valid_q ? nv_trim_hi_q : `PDCC_RST_TRIM_HI;
      trim_lo_q  <= nv_valid_q ? nv_trim_lo_q : `PDCC_RST_TRIM_LO;
      bus_addr_q <= nv_valid_q ? {4'hf, nv_bus_addr_q} : `PDCC_RST_BUS_ADDR;
      band_q     <= nv_valid_q ? nv_band_q : FACTORY_BAND;
    end else if (wr_stb) begin
      if (reg_addr == `PDCC_REG_DIV) begin
        div_ctrl_q <= wr_data;
      end else if (reg_addr == `PDCC_REG_TRIM_HI) begin
        trim_hi_q <= wr_data;
      end else if (reg_addr == `PDCC_REG_TRIM_LO) begin
        trim_lo_q <= {wr_data[7:6], 6'h00};
      end else if (reg_addr == `PDCC_REG_BUS_ADDR) begin
        bus_addr_q <= {4'hf, wr_data[3:0]};
      end else if (reg_addr == `PDCC_REG_BAND) begin
        band_q <= wr_data[4:0];
      end
    end
  end

  // Nonvolatile shadow; the write takes a long busy period, and commits issued while busy are dropped.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      nv_cnt_q  <= 24'h000000;
      nv_busy_o <= 1'b0;
    end else if (nv_busy_o) begin
      nv_cnt_q  <= nv_cnt_q - 24'h000001;
      nv_busy_o <= (nv_cnt_q != 24'h000001);
    end else if (nv_write) begin
      nv_cnt_q  <= NV_WRITE_CYCLES;
      nv_busy_o <= 1'b1;
    end
  end

  // The shadow stands in for nonvolatile cells, so a power-up reset leaves it alone.
  always @(posedge core_clk_i) begin
    if (commit_stb && !nv_busy_o) begin
      nv_valid_q    <= 1'b1;
      nv_div_q      <= div_ctrl_q;
      nv_trim_hi_q  <= trim_hi_q;
      nv_trim_lo_q  <= trim_lo_q;
      nv_bus_addr_q <= bus_addr_q[3:0];
      nv_band_q     <= band_q;
    end
  end

  // Pin inputs cross into the core clock through two flops; the third stage finds edges.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      dith_sync_q <= 3'h0;
      oe_sync_q   <= 3'h0;
      pdn_sync_q  <= 3'h0;
      osc_sync_q  <= 3'h0;
    end else begin
      dith_sync_q <= {dith_sync_q[1:0], dither_enable_pin_i};
      oe_sync_q   <= {oe_sync_q[1:0], output_enable_pin_i};
      pdn_sync_q  <= {pdn_sync_q[1:0], power_down_pin_i};
      osc_sync_q  <= {osc_sync_q[1:0], osc_clk_i};
    end
  end

  // Power-down low must persist through the deglitch window before it takes effect.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      pdn_cnt_q <= 12'h000;
      pdn_low_q <= 1'b0;
    end else if (pdn_sync_q[1]) begin
      pdn_cnt_q <= 12'h000;
      pdn_low_q <= 1'b0;
    end else if (pdn_cnt_q != PDN_HOLD) begin
      pdn_cnt_q <= pdn_cnt_q + 12'h001;
    end else begin
      pdn_low_q <= 1'b1;
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      osc_run_o <= 1'b0;
    end else begin
      // Stopping waits for a low output phase, so power-down never cuts a pulse short.
      osc_run_o <= ~pdn_low_q | (osc_run_o & (clk_out_o | osc_edge));
    end
  end

  // Startup wait counts oscillator edges; it restarts after each power-down.
  always @(posedge core_clk_i) begin
    if (srst_i || pdn_low_q) begin
      stab_cnt_q <= 10'h000;
      stable_q   <= 1'b0;
    end else if (osc_edge && !stable_q) begin
      stab_cnt_q <= stab_cnt_q + 10'h001;
      stable_q   <= (stab_cnt_q == `PDCC_STAB_CYCLES - 10'h001);
    end
  end

  always @* begin
    exp_eff = div_ctrl_q[3:0];
    if (div_ctrl_q[3:0] > `PDCC_EXP_MAX) begin
      exp_eff = `PDCC_EXP_MAX;
    end
  end

  // Divider runs off oscillator edges; the gate only changes at a divided-clock low
  // phase boundary so an enable never produces a partial pulse.
  always @(posedge core_clk_i) begin
    if (srst_i || !osc_run_o) begin
      div_cnt_q  <= 9'h000;
      out_gate_q <= 1'b0;
      clk_out_o  <= 1'b0;
    end else if (osc_edge) begin
      div_cnt_q <= div_cnt_q + 9'h001;
      if (exp_eff == 4'h0) begin
        clk_out_o <= out_gate_q;
      end else begin
        if (div_wrap) begin
          out_gate_q <= oe_sync_q[1] & stable_q;
        end
        clk_out_o <= out_gate_q & div_cnt_q[exp_eff - 4'h1];
      end
    end else if (osc_fall && exp_eff == 4'h0) begin
      // Undivided output follows the oscillator; the gate moves only in its low half.
      out_gate_q <= oe_sync_q[1] & stable_q;
      clk_out_o  <= 1'b0;
    end
  end

  // Triangle dither: offset ramps up and back down; peak amount from the amount bit.
  always @(posedge core_clk_i) begin
    if (srst_i) begin
      tri_cnt_q       <= 8'h00;
      tri_up_q        <= 1'b1;
      dither_offset_o <= 4'h0;
    end else if (!dith_sync_q[1]) begin
      tri_cnt_q       <= 8'h00;
      tri_up_q        <= 1'b1;
      dither_offset_o <= 4'h0;
    end else if (osc_edge) begin
      tri_cnt_q <= tri_up_q ? tri_cnt_q + 8'h01 : tri_cnt_q - 8'h01;
      if (tri_cnt_q == `PDCC_DITHER_STEPS - 8'h02 && tri_up_q) begin
        tri_up_q <= 1'b0;
      end else if (tri_cnt_q == 8'h01 && !tri_up_q) begin
        tri_up_q <= 1'b1;
      end
      if (div_ctrl_q[`PDCC_DITHER_BIT]) begin
        dither_offset_o <= {1'b0, tri_cnt_q[5:3]};
      end else begin
        dither_offset_o <= tri_cnt_q[5:2];
      end
    end
  end

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      freq_trim_o <= 10'h000;
      band_sel_o  <= 5'h00;
    end else begin
      freq_trim_o <= {trim_hi_q, trim_lo_q[7:6]};
      band_sel_o  <= band_q;
    end
  end
endmodule
`default_nettype wire

/* rtl/pdcc_defines.vh */
// Constants shared by the dither clock control block.
// Notes on behaviour
// - Dither active only while dither pin high.
// - Output-enable gates output; oscillator keeps running.
// - Power-down low stops oscillator and output.
// - Sample on serial clock rise, drive on fall.
// - Serial data pin only pulls low or releases.
// - Output divides oscillator by two to exponent.
// - Exponents above eight act as eight.
// - Triangle generator dithers by 2% or 4%.
// - Amount bit one gives 2%, zero 4%.
// - Trim word ten bits, high byte plus two.
// - Zero-reading unused bits always read zero.
// - Frequency is band minimum plus trim steps.
// - Band select picks one of thirteen bands.
// - Read-only copy returns factory band value.
// - Band select defaults to factory band value.
// - Output held off for 512 oscillator cycles.
// - Enables synchronised, no partial output pulse.
// - Registers written by serial bus, reloaded nonvolatile.
// - Commit command copies registers to nonvolatile store.
`ifndef PDCC_DEFINES_VH
`define PDCC_DEFINES_VH
`define PDCC_REG_DIV         6'h02
`define PDCC_REG_TRIM_HI     6'h08
`define PDCC_REG_TRIM_LO     6'h09
`define PDCC_REG_BUS_ADDR    6'h0d
`define PDCC_REG_BAND        6'h0e
`define PDCC_REG_BAND_REF    6'h37
`define PDCC_REG_COMMIT      6'h3f
`define PDCC_RST_DIV         8'he0
`define PDCC_RST_TRIM_HI     8'h7d
`define PDCC_RST_TRIM_LO     8'h00
`define PDCC_RST_BUS_ADDR    8'hf0
`define PDCC_DIV_ONES        8'he0
`define PDCC_ADDR_ONES       8'hf0
`define PDCC_BAND_ONES       8'he0
`define PDCC_EXP_MAX         4'h8
`define PDCC_DITHER_BIT      4
`define PDCC_WC_BIT          3
`define PDCC_DEV_ADDR_HI     4'hb
`define PDCC_STAB_CYCLES     10'h200
`define PDCC_PDN_HOLD_US     10
`define PDCC_NV_WRITE_MS     10
`define PDCC_CLK_MHZ         100
`define PDCC_DITHER_STEPS    8'h40
`endif

/* rtl/pdcc_serial_slave.v */
// Two-wire serial slave that reads and writes the byte-wide register bank.
`timescale 1ns/10ps
`default_nettype none
`include "pdcc_defines.vh"
module pdcc_serial_slave (
  input  wire       core_clk_i,
  input  wire       srst_i,
  input  wire       scl_i,
  input  wire       sda_i,
  input  wire [2:0] dev_addr_i,
  input  wire [7:0] rd_data_i,
  output wire       sda_oe_o,
  output reg  [5:0] reg_addr_o,
  output reg  [7:0] wr_data_o,
  output reg        ptr_stb_o,
  output reg        wr_stb_o
);
  localparam ST_IDLE = 3'h0;
  localparam ST_DEV  = 3'h1;
  localparam ST_PTR  = 3'h2;
  localparam ST_WR   = 3'h3;
  localparam ST_RD   = 3'h4;
  localparam ST_ACK  = 3'h5;
  localparam ST_RACK = 3'h6;

  reg [1:0] scl_sync_q;
  reg [1:0] sda_sync_q;
  reg       scl_q;
  reg       sda_q;
  reg [2:0] state_q;
  reg [2:0] next_q;
  reg [3:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg       sda_low_q;
  reg       is_read_q;

  wire scl_rise = scl_sync_q[1] & ~scl_q;
  wire scl_fall = ~scl_sync_q[1] & scl_q;
  wire start    = scl_sync_q[1] & scl_q & sda_q & ~sda_sync_q[1];
  wire stop     = scl_sync_q[1] & scl_q & ~sda_q & sda_sync_q[1];

  // The pin is only ever pulled low or released.
  assign sda_oe_o = sda_low_q;

  always @(posedge core_clk_i) begin
    if (srst_i) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      state_q    <= ST_IDLE;
      next_q     <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 8'h00;
      sda_low_q  <= 1'b0;
      is_read_q  <= 1'b0;
      reg_addr_o <= 6'h00;
      wr_data_o  <= 8'h00;
      wr_stb_o   <= 1'b0;
      ptr_stb_o  <= 1'b0;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_i};
      sda_sync_q <= {sda_sync_q[0], sda_i};
      scl_q      <= scl_sync_q[1];
      sda_q      <= sda_sync_q[1];
      wr_stb_o   <= 1'b0;
      ptr_stb_o  <= 1'b0;
      if (start) begin
        state_q   <= ST_DEV;
        bit_cnt_q <= 4'h0;
        sda_low_q <= 1'b0;
      end else if (stop) begin
        state_q   <= ST_IDLE;
        sda_low_q <= 1'b0;
      end else if (scl_rise) begin
        // Incoming bits are taken on the rising serial clock.
        case (state_q)
          ST_DEV, ST_PTR, ST_WR: begin
            shift_q   <= {shift_q[6:0], sda_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          ST_RD: begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
          ST_RACK: begin
            if (sda_q) begin
              next_q <= ST_IDLE;
            end else begin
              next_q <= ST_RD;
            end
          end
          default: begin
          end
        endcase
      end else if (scl_fall) begin
        // Outgoing bits change only on the falling serial clock.
        case (state_q)
          ST_DEV: begin
            if (bit_cnt_q == 4'h8) begin
              if (shift_q[7:1] == {`PDCC_DEV_ADDR_HI, dev_addr_i}) begin
                is_read_q <= shift_q[0];
                sda_low_q <= 1'b1;
                state_q   <= ST_ACK;
                next_q    <= shift_q[0] ? ST_RD : ST_PTR;
              end else begin
                state_q <= ST_IDLE;
              end
            end
          end
          ST_PTR, ST_WR: begin
            if (bit_cnt_q == 4'h8) begin
              sda_low_q <= 1'b1;
              state_q   <= ST_ACK;
              next_q    <= ST_WR;
              if (state_q == ST_PTR) begin
                // A pointer byte alone is a command, so it is flagged.
                reg_addr_o <= shift_q[5:0];
                ptr_stb_o  <= 1'b1;
              end else begin
                wr_data_o <= shift_q;
                wr_stb_o  <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            bit_cnt_q <= 4'h0;
            state_q   <= next_q;
            if (next_q == ST_RD) begin
              shift_q   <= {rd_data_i[6:0], 1'b0};
              sda_low_q <= ~rd_data_i[7];
            end else begin
              sda_low_q <= 1'b0;
            end
            if (next_q == ST_WR && !is_read_q && bit_cnt_q == 4'h8 && wr_stb_o == 1'b0) begin
              reg_addr_o <= reg_addr_o;
            end
          end
          ST_RD: begin
            if (bit_cnt_q == 4'h8) begin
              sda_low_q  <= 1'b0;
              state_q    <= ST_RACK;
              reg_addr_o <= reg_addr_o + 6'h01;
            end else begin
              sda_low_q <= ~shift_q[7];
              shift_q   <= {shift_q[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            bit_cnt_q <= 4'h0;
            state_q   <= next_q;
            if (next_q == ST_RD) begin
              shift_q   <= {rd_data_i[6:0], 1'b0};
              sda_low_q <= ~rd_data_i[7];
            end
          end
          default: begin
          end
        endcase
      end
      if (wr_stb_o) begin
        reg_addr_o <= reg_addr_o + 6'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/pdcc_properties.sv */
// Port-level checker for the dither clock control block.
`timescale 1ns/10ps
`default_nettype none
module pdcc_properties (
  input wire logic       core_clk_i,
  input wire logic       srst_i,
  input wire logic       dither_enable_pin_i,
  input wire logic       output_enable_pin_i,
  input wire logic       power_down_pin_i,
  input wire logic       scl_i,
  input wire logic       sda_oe_o,
  input wire logic       clk_out_o,
  input wire logic       osc_run_o,
  input wire logic [3:0] dither_offset_o,
  input wire logic       nv_busy_o
);
  logic [11:0] up_q, pdn_lo_q, pdn_hi_q, oe_lo_q, spr_lo_q, scl_hi_q;
  function automatic logic [11:0] sat(input logic [11:0] v);
    return v + {11'h0, v != 12'hfff};
  endfunction
  // Saturating counters stand in for long repetitions, which the tools unroll badly.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      {up_q, pdn_lo_q, pdn_hi_q, oe_lo_q, spr_lo_q, scl_hi_q} <= '0;
    end else begin
      up_q     <= sat(up_q);
      pdn_lo_q <= power_down_pin_i ? 12'h0 : sat(pdn_lo_q);
      pdn_hi_q <= power_down_pin_i ? sat(pdn_hi_q) : 12'h0;
      oe_lo_q  <= output_enable_pin_i ? 12'h0 : sat(oe_lo_q);
      spr_lo_q <= dither_enable_pin_i ? 12'h0 : sat(spr_lo_q);
      scl_hi_q <= scl_i ? sat(scl_hi_q) : 12'h0;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  a_startup_output_off: assert property (up_q < 12'd2000 |-> !clk_out_o)
    else $error("output active during startup wait");
  a_pdn_stops_all: assert property (pdn_lo_q > 12'd2000 |-> !osc_run_o && !clk_out_o)
    else $error("power-down did not stop oscillator and output");
  a_osc_keeps_running: assert property (pdn_hi_q > 12'd3500 |-> osc_run_o)
    else $error("oscillator stopped while powered");
  a_oe_gates_out: assert property (oe_lo_q > 12'd1200 |-> !clk_out_o)
    else $error("output active while disabled");
  a_dither_off_low: assert property (spr_lo_q > 12'd4000 |-> dither_offset_o == 4'h0)
    else $error("dither offset while dither pin low");
  a_sda_on_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("serial data changed while serial clock high");
  a_sda_idle_free: assert property (scl_hi_q > 12'd8 |-> !sda_oe_o)
    else $error("serial data held low on idle bus");
  a_commit_busy_holds: assert property ($rose(nv_busy_o) |-> nv_busy_o [*8])
    else $error("commit busy too short");
  a_no_runt_high: assert property ($rose(clk_out_o) |=> clk_out_o)
    else $error("runt high pulse on output");
  a_no_runt_low: assert property ($fell(clk_out_o) |=> !clk_out_o)
    else $error("runt low pulse on output");
endmodule
bind pdcc_clock_ctrl pdcc_properties u_props (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .dither_enable_pin_i(dither_enable_pin_i),
  .output_enable_pin_i(output_enable_pin_i), .power_down_pin_i(power_down_pin_i), .scl_i(scl_i),
  .sda_oe_o(sda_oe_o), .clk_out_o(clk_out_o), .osc_run_o(osc_run_o), .dither_offset_o(dither_offset_o),
  .nv_busy_o(nv_busy_o));
`default_nettype wire

/* testbench/pdcc_host_model.sv */
// Two-wire bus controller model that issues register cycles to the block.
`timescale 1ns/10ps
`default_nettype none
`include "pdcc_defines.vh"
module pdcc_host_model (
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  localparam logic [7:0] DEV = {`PDCC_DEV_ADDR_HI, 4'h0};
  logic nak_q;
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
    nak_q    = 1'b0;
  end
  // Data moves mid-way through the low phase, so it is settled at the rise.
  task automatic bit_io(input logic b, output logic r);
    #20 sda_oe_o = !b;
    #20 scl_o = 1'b1;
    r = sda_i;
    #40 scl_o = 1'b0;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(1'b1, r);
    if (!last) nak_q |= r;
  endtask
  task automatic start_c;
    #20 sda_oe_o = 1'b1;
    #40 scl_o = 1'b0;
  endtask
  // The clock stands high between frames.
  task automatic stop_c;
    #20 sda_oe_o = 1'b1;
    #20 scl_o = 1'b1;
    #20 sda_oe_o = 1'b0;
    #200;
  endtask
  task automatic cmd(input logic [7:0] a);
    logic [7:0] q;
    start_c();
    byte_io(DEV, 1'b0, q);
    byte_io(a, 1'b0, q);
    stop_c();
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    start_c();
    byte_io(DEV, 1'b0, q);
    byte_io(a, 1'b0, q);
    byte_io(d, 1'b0, q);
    stop_c();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    cmd(a);
    start_c();
    byte_io(DEV | 8'h01, 1'b0, q);
    byte_io(8'hff, 1'b1, d);
    stop_c();
  endtask
endmodule
`default_nettype wire

/* testbench/programmable_dither_clock_ctrl_test.sv */
// Self-checking bench for the dither clock control block.
`timescale 1ns/10ps
`default_nettype none
module programmable_dither_clock_ctrl_test;
  localparam logic [4:0] FB = 5'h12;
  logic            core_clk_i, srst_i, osc_clk_i, spr_i, oe_i, pdn_i;
  wire             scl, sda, host_oe, dev_oe, clk_out, osc_run, nv_busy;
  wire       [9:0] trim;
  wire       [4:0] band;
  wire       [3:0] offs;
  int              n_errors = 0;
  int              n_checks = 0;
  int              busy_cycles = 0;
  assign sda = !(host_oe || dev_oe);
  pdcc_clock_ctrl #(.FACTORY_BAND(FB), .NV_WRITE_CYCLES(24'd20)) uut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .osc_clk_i(osc_clk_i), .dither_enable_pin_i(spr_i),
    .output_enable_pin_i(oe_i), .power_down_pin_i(pdn_i), .scl_i(scl), .sda_i(sda), .sda_oe_o(dev_oe),
    .clk_out_o(clk_out), .osc_run_o(osc_run), .freq_trim_o(trim), .band_sel_o(band),
    .dither_offset_o(offs), .nv_busy_o(nv_busy));
  pdcc_host_model host (.scl_o(scl), .sda_oe_o(host_oe), .sda_i(sda));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  // The oscillator runs at four core cycles a period, so output periods are exact.
  initial begin
    osc_clk_i = 1'b0;
    forever #20 osc_clk_i = ~osc_clk_i;
  end
  always @(posedge core_clk_i) if (nv_busy === 1'b1) busy_cycles <= busy_cycles + 1;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input string w, input logic [11:0] e, input logic [11:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input string w);
    logic [7:0] d;
    host.rd(a, d);
    chk(w, {4'h0, e}, {4'h0, d & m});
  endtask
  task automatic meas(output logic [11:0] p);
    logic l;
    int   e;
    l = clk_out;
    e = 0;
    p = 12'h0;
    for (int c = 0; c < 4000 && e < 2; c++) begin
      tick(1);
      if (e == 1) p++;
      if (clk_out === 1'b1 && l === 1'b0) e++;
      l = clk_out;
    end
  endtask
  task automatic t_defaults;
    rdchk(8'h02, 8'he0, 8'hff, "div reset");
    rdchk(8'h08, 8'h7d, 8'hff, "trim hi reset");
    rdchk(8'h09, 8'h00, 8'hff, "trim lo reset");
    rdchk(8'h0d, 8'hf0, 8'hff, "addr reset");
    rdchk(8'h0e, {3'h7, FB}, 8'hff, "band reset");
    rdchk(8'h37, {3'h0, FB}, 8'h1f, "band ref");
    chk("trim out", 12'h1f4, {2'h0, trim});
    chk("band out", {7'h0, FB}, {7'h0, band});
    $display("t_defaults done");
  endtask
  task automatic t_fields;
    host.wr(8'h08, 8'ha3);
    host.wr(8'h09, 8'hff);
    rdchk(8'h09, 8'hc0, 8'hff, "trim lo zeros");
    chk("trim word", 12'h28f, {2'h0, trim});
    host.wr(8'h02, 8'h1f);
    rdchk(8'h02, 8'hff, 8'hff, "div ones");
    host.wr(8'h0d, 8'h00);
    rdchk(8'h0d, 8'hf0, 8'hff, "addr ones");
    host.wr(8'h0e, 8'h10);
    rdchk(8'h0e, 8'hf0, 8'hff, "band write");
    chk("band out", 12'h010, {7'h0, band});
    host.wr(8'h37, 8'h00);
    rdchk(8'h37, {3'h0, FB}, 8'h1f, "band ref kept");
    $display("t_fields done");
  endtask
  task automatic t_divider;
    logic [3:0]  ex [6] = '{4'h0, 4'h1, 4'h3, 4'h8, 4'h9, 4'hf};
    logic [11:0] p;
    foreach (ex[i]) begin
      host.wr(8'h02, {4'h0, ex[i]});
      meas(p);
      meas(p);
      chk("period", 12'(4 << (ex[i] > 4'h8 ? 8 : ex[i])), p);
    end
    $display("t_divider done");
  endtask
  task automatic t_gates;
    logic [11:0] p;
    oe_i = 1'b0;
    tick(1300);
    chk("oe off out", 12'h0, {11'h0, clk_out});
    chk("oe off osc", 12'h1, {11'h0, osc_run});
    oe_i = 1'b1;
    meas(p);
    chk("oe on period", 12'd1024, p);
    pdn_i = 1'b0;
    tick(2200);
    chk("pdn osc", 12'h0, {11'h0, osc_run});
    chk("pdn out", 12'h0, {11'h0, clk_out});
    pdn_i = 1'b1;
    tick(3600);
    chk("pdn resume", 12'h1, {11'h0, osc_run});
    $display("t_gates done");
  endtask
  task automatic t_dither;
    logic [3:0] mx [2];
    spr_i = 1'b1;
    for (int j = 0; j < 2; j++) begin
      host.wr(8'h02, {3'h0, j[0], 4'h0});
      mx[j] = 4'h0;
      repeat (4000) begin
        tick(1);
        if (offs > mx[j]) mx[j] = offs;
      end
    end
    chk("dither runs", 12'h1, {11'h0, mx[0] != 4'h0});
    chk("dither 2pc less", 12'h1, {11'h0, mx[1] < mx[0]});
    spr_i = 1'b0;
    tick(4100);
    chk("undithered", 12'h0, {8'h0, offs});
    $display("t_dither done");
  endtask
  task automatic t_commit;
    int b0;
    b0 = busy_cycles;
    host.cmd(8'h3f);
    tick(40);
    chk("commit busy", 12'd20, 12'(busy_cycles - b0));
    chk("commit done", 12'h0, {11'h0, nv_busy});
    srst_i = 1'b1;
    tick(16);
    srst_i = 1'b0;
    tick(3000);
    rdchk(8'h0e, 8'hf0, 8'hff, "band reload");
    rdchk(8'h08, 8'ha3, 8'hff, "trim reload");
    chk("bus acks", 12'h0, {11'h0, host.nak_q});
    $display("t_commit done");
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #800000;
    n_errors++;
    $display("[ERR] watchdog expected done seen hang");
    finish_test();
  end
  initial begin
    srst_i = 1'b1;
    spr_i  = 1'b0;
    oe_i   = 1'b1;
    pdn_i  = 1'b1;
    tick(16);
    srst_i = 1'b0;
    tick(3000);
    t_defaults();
    t_fields();
    t_divider();
    t_gates();
    t_dither();
    t_commit();
    finish_test();
  end
endmodule
`default_nettype wire
